// file: rtl/pxb_bridge.sv
`timescale 1ns/100ps
`include "pxb_map.svh"
module pxb_bridge #(
	parameter int WCMD_DEPTH = `PXB_WCMD_DEPTH,
	parameter int SPLIT_MAX = `PXB_SPLIT_MAX
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic pcix_mode,
	input wire logic req_valid,
	input wire pxb_pkg::pxb_req_t req,
	input wire logic req_reg,
	output pxb_pkg::pxb_ans_t ans,
	output logic [7:0] ans_tag,
	input wire logic wbeat_valid,
	output logic wbeat_ready,
	input wire pxb_pkg::pxb_beat_t wbeat,
	output logic rbeat_valid,
	input wire logic rbeat_ready,
	output pxb_pkg::pxb_beat_t rbeat,
	output logic rbeat_split,
	output logic [7:0] rbeat_tag,
	output logic lnk_valid,
	input wire logic lnk_ready,
	output pxb_pkg::pxb_lnk_t lnk,
	output logic lnk_reg,
	input wire logic lnk_wdata_ready,
	output pxb_pkg::pxb_beat_t lnk_wdata,
	output logic lnk_wdata_valid,
	input wire logic lnk_rdata_valid,
	input wire pxb_pkg::pxb_beat_t lnk_rdata,
	input wire logic [2:0] lnk_rdata_slot,
	output logic lnk_rdata_ready,
	input wire logic lnk_mst_req,
	input wire logic mst_gnt,
	output logic mst_req,
	output logic [12:0] mst_rd_limit
);
	import pxb_pkg::*;
	localparam int CW = $clog2(WCMD_DEPTH + 1);
	// ==========================================================
	// Request classification
	// ==========================================================
	wire is_rd = req_valid && req.cmd == PXB_MEM_RD;
	wire is_wr = req_valid && req.cmd == PXB_MEM_WR;
	wire is_ign = req_valid && (req.cmd == PXB_IO || req.cmd == PXB_CFG); // see R9
	function automatic logic [12:0] clip(input logic [12:0] n,
		input logic [12:0] lim);
		return (n > lim || n == 13'h0000) ? lim : n;
	endfunction
	// Single-address cycles carry a 32-bit address; upper half forced to zero
	function automatic logic [63:0] ext_addr(input pxb_req_t r);
		return r.dac ? r.addr : {32'h0, r.addr[31:0]};
	endfunction
	// Conventional prefetch fixed at its cap; extended follows byte count
	wire [12:0] pf_len = pcix_mode ? clip(req.bcount, `PXB_RD_BUF_BYTES) :
		`PXB_PCI_PF_BYTES; // see R4, R12, R13
	// ==========================================================
	// Outstanding read slots
	// ==========================================================
	logic [SPLIT_MAX-1:0] busy_ff, nxt_busy;
	logic [SPLIT_MAX-1:0] sent_ff;
	logic [63:0] saddr_ff [SPLIT_MAX];
	logic [7:0] stag_ff [SPLIT_MAX];
	logic [12:0] slen_ff [SPLIT_MAX];
	logic done_ff;
	logic [2:0] free_idx;
	logic have_free;
	always_comb begin
		free_idx = 3'h0;
		have_free = 1'b0;
		for (int i = SPLIT_MAX - 1; i >= 0; i--) begin
			if (!busy_ff[i]) begin
				free_idx = 3'(i);
				have_free = 1'b1;
			end
		end
	end
	// Only slot 0 is used in conventional mode
	wire pci_hit = busy_ff[0] && saddr_ff[0] == ext_addr(req);
	wire pci_take = !pcix_mode && is_rd && !busy_ff[0]; // see R2, R5
	wire pci_deliver = !pcix_mode && is_rd && pci_hit && done_ff; // see R3
	wire x_take = pcix_mode && is_rd && have_free; // see R10, R11
	wire take_rd = pci_take || x_take;
	wire [2:0] take_idx = pcix_mode ? free_idx : 3'h0;
	// ==========================================================
	// Posted write queue
	// ==========================================================
	logic [CW-1:0] wcmd_lvl;
	logic [13:0] wbytes_ff;
	logic [12:0] rt_bytes;
	logic rt_valid;
	wire wq_full = wcmd_lvl == CW'(WCMD_DEPTH) ||
		wbytes_ff + {1'b0, req.bcount} > {1'b0, `PXB_WDATA_BYTES};
	wire take_wr = is_wr && !wq_full; // see R7, R15, R20
	// ==========================================================
	// Answer to the requester
	// ==========================================================
	pxb_ans_t nxt_ans;
	always_comb begin
		if (is_ign || !req_valid) begin
			nxt_ans = PXB_ANS_NONE;
		end else if (is_wr) begin
			nxt_ans = take_wr ? PXB_ANS_ACK : PXB_ANS_RETRY; // see R8
		end else if (pcix_mode) begin
			nxt_ans = x_take ? PXB_ANS_SPLIT : PXB_ANS_RETRY;
		end else begin
			nxt_ans = pci_deliver ? PXB_ANS_ACK : PXB_ANS_RETRY; // see R21
		end
	end
	// ==========================================================
	// Linkage requests: captured reads first, then posted writes
	// ==========================================================
	logic [SPLIT_MAX-1:0] pend;
	logic [2:0] pend_idx;
	logic pend_any;
	always_comb begin
		pend_idx = 3'h0;
		pend_any = 1'b0;
		for (int i = SPLIT_MAX - 1; i >= 0; i--) begin
			pend[i] = busy_ff[i] && !sent_ff[i];
			if (pend[i]) begin
				pend_idx = 3'(i);
				pend_any = 1'b1;
			end
		end
	end
	localparam int LB = $bits(pxb_lnk_t);
	logic lk_ff, lk_wr_ff;
	logic [2:0] lk_idx_ff;
	logic cq_valid;
	logic [LB:0] cq_out;
	pxb_lnk_t cq_cmd;
	// A stalled link request must stand, so the choice freezes until taken
	wire use_wr = lk_ff ? lk_wr_ff : !pend_any;
	wire [2:0] rd_idx = lk_ff ? lk_idx_ff : pend_idx;
	wire cq_reg = cq_out[LB];
	assign cq_cmd = pxb_lnk_t'(cq_out[LB-1:0]);
	wire [LB:0] cq_in = {req_reg, pxb_lnk_t'{1'b1, ext_addr(req),
		req.bcount, 3'h0}};
	wire lnk_go = lnk_valid && lnk_ready;
	assign lnk_valid = lk_ff || pend_any || cq_valid; // see R6, R18
	assign lnk = use_wr ? cq_cmd : pxb_lnk_t'{1'b0, saddr_ff[rd_idx],
		slen_ff[rd_idx], rd_idx};
	assign lnk_reg = use_wr && cq_reg; // see R19
	wire wr_issue = lnk_go && use_wr;
	wire rd_issue = lnk_go && !use_wr;
	// Posted commands wait here until the linkage takes them
	pxb_fifo #(.WIDTH(LB + 1), .DEPTH(WCMD_DEPTH)) u_cq (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(take_wr),
		.in_ready(),
		.in_data(cq_in),
		.out_valid(cq_valid),
		.out_ready(wr_issue),
		.out_data(cq_out),
		.level()
	);
	// Write data beats toward the linkage, staged in the beat FIFO
	pxb_fifo #(.WIDTH($bits(pxb_beat_t)), .DEPTH(`PXB_BEAT_FIFO_DEPTH)) u_wq (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(wbeat_valid),
		.in_ready(wbeat_ready),
		.in_data(wbeat),
		.out_valid(lnk_wdata_valid),
		.out_ready(lnk_wdata_ready),
		.out_data(lnk_wdata),
		.level()
	);
	wire wbeat_last_out = lnk_wdata_valid && lnk_wdata_ready && lnk_wdata.last;
	// Byte counts stay until the last beat leaves, so queue space is
	// released only once the write has really drained
	wire rt_pop = wbeat_last_out && rt_valid;
	pxb_fifo #(.WIDTH(13), .DEPTH(WCMD_DEPTH)) u_rt (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(take_wr),
		.in_ready(),
		.in_data(req.bcount),
		.out_valid(rt_valid),
		.out_ready(rt_pop),
		.out_data(rt_bytes),
		.level(wcmd_lvl)
	);
	// ==========================================================
	// Read data returned from the linkage
	// ==========================================================
	// Beat is held in the output stage; back-pressure reaches the linkage
	assign lnk_rdata_ready = !rbeat_valid || rbeat_ready;
	wire rd_in = lnk_rdata_valid && lnk_rdata_ready;
	wire rd_end = rd_in && lnk_rdata.last;
	logic rv_ff;
	assign rbeat_valid = rv_ff;
	always_comb begin
		nxt_busy = busy_ff;
		if (rd_end && pcix_mode) nxt_busy[lnk_rdata_slot] = 1'b0;
		if (pci_deliver) nxt_busy[0] = 1'b0;
		if (take_rd) nxt_busy[take_idx] = 1'b1;
	end
	// ==========================================================
	// Host bus master request
	// ==========================================================
	assign mst_req = lnk_mst_req && !mst_gnt; // see R16
	assign mst_rd_limit = pcix_mode ? `PXB_MST_BUF_BYTES :
		`PXB_PCI_PF_BYTES; // see R17
	// ==========================================================
	// State
	// ==========================================================
	always_ff @(posedge mclk) begin
		if (take_rd) begin
			saddr_ff[take_idx] <= ext_addr(req);
			stag_ff[take_idx] <= req.tag;
			slen_ff[take_idx] <= pf_len; // see R1
		end
		if (rd_in) begin
			rbeat <= lnk_rdata;
			rbeat_tag <= pcix_mode ? stag_ff[lnk_rdata_slot] : 8'h00;
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			busy_ff <= '0;
			sent_ff <= '0;
			done_ff <= 1'b0;
			wbytes_ff <= 14'h0000;
			lk_ff <= 1'b0;
			lk_wr_ff <= 1'b0;
			lk_idx_ff <= 3'h0;
			ans <= PXB_ANS_NONE;
			ans_tag <= 8'h00;
			rv_ff <= 1'b0;
			rbeat_split <= 1'b0;
		end else begin
			busy_ff <= nxt_busy;
			ans <= nxt_ans;
			ans_tag <= req.tag;
			if (rd_issue) sent_ff[rd_idx] <= 1'b1;
			if (take_rd) sent_ff[take_idx] <= 1'b0;
			if (pci_deliver) done_ff <= 1'b0;
			if (rd_end && !pcix_mode) done_ff <= 1'b1;
			lk_ff <= lnk_valid && !lnk_ready;
			lk_wr_ff <= use_wr;
			lk_idx_ff <= rd_idx;
			wbytes_ff <= wbytes_ff + (take_wr ? {1'b0, req.bcount} : 14'h0) -
				(rt_pop ? {1'b0, rt_bytes} : 14'h0);
			if (rd_in) rv_ff <= 1'b1;
			else if (rbeat_ready) rv_ff <= 1'b0;
			if (rd_in) rbeat_split <= pcix_mode; // see R14
		end
	end
endmodule

// file: rtl/pxb_map.svh
`ifndef PXB_MAP_SVH
`define PXB_MAP_SVH
// Overview of operation
// R1: Host side carries 32-bit and 64-bit address and data in both modes.
// R2: Conventional mode handles every read as a delayed transaction.
// R3: Conventional read is retried; requester reissues same request for data.
// R4: Conventional mode prefetches at most 512 bytes of the 4 Kbyte buffer.
// R5: Conventional mode tracks only one outstanding delayed read.
// R6: Captured read is passed to the linkage arbiter toward the VME master.
// R7: Conventional writes post into 40-entry command and 4 Kbyte data queues.
// R8: Posted write completes at once, then goes to VME without the master.
// R9: No I/O-space response, lock ignored, no message-signalled interrupts.
// R10: Extended mode answers every read with a split response; the bridge answers retry while all six slots are busy.
// R11: Extended mode tracks up to six outstanding split reads.
// R12: Extended mode sizes prefetch from the requester's byte count.
// R13: Extended mode may use the whole 4 Kbyte read buffer.
// R14: Arrived read data starts a split completion to the requester.
// R15: Extended writes post into same queues, acknowledged at once.
// R16: Master requests host bus only when linkage asks it to serve.
// R17: Master has 4 Kbyte read and write buffers; usable read size by mode.
// R18: All traffic with the device passes through the linkage arbiter.
// R19: Register accesses route only through the linkage arbiter.
// R20: A new write is retried while either write queue is full.
// R21: Non-matching conventional read is retried without capture while busy.
`define PXB_RD_BUF_BYTES 13'h1000
`define PXB_PCI_PF_BYTES 13'h0200
`define PXB_WCMD_DEPTH 40
`define PXB_WDATA_BYTES 13'h1000
`define PXB_SPLIT_MAX 6
`define PXB_MST_BUF_BYTES 13'h1000
`define PXB_BEAT_FIFO_DEPTH 16
`endif

// file: rtl/pxb_pkg.sv
package pxb_pkg;
	typedef enum logic [1:0] {PXB_MEM_RD, PXB_MEM_WR, PXB_IO, PXB_CFG} pxb_cmd_t;
	typedef enum logic [1:0] {PXB_ANS_NONE, PXB_ANS_RETRY, PXB_ANS_ACK,
		PXB_ANS_SPLIT} pxb_ans_t;
	typedef struct packed {
		pxb_cmd_t cmd;
		logic [63:0] addr;
		logic dac;
		logic [12:0] bcount;
		logic [7:0] tag;
		logic lock;
	} pxb_req_t;
	typedef struct packed {
		logic wr;
		logic [63:0] addr;
		logic [12:0] bcount;
		logic [2:0] slot;
	} pxb_lnk_t;
	typedef struct packed {
		logic [63:0] data;
		logic [7:0] be;
		logic last;
	} pxb_beat_t;
endpackage

// file: rtl/pxb_fifo.sv
`timescale 1ns/100ps
module pxb_fifo #(
	parameter int WIDTH = 73,
	parameter int DEPTH = 16
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wp_ff, rp_ff;
	logic [$clog2(DEPTH+1)-1:0] cnt_ff;
	wire do_wr = in_valid && in_ready;
	wire do_rd = out_valid && out_ready;
	assign in_ready = cnt_ff != DEPTH[$clog2(DEPTH+1)-1:0];
	assign out_valid = cnt_ff != '0;
	assign out_data = mem_ff[rp_ff];
	assign level = cnt_ff;
	function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction
	always_ff @(posedge mclk) begin
		if (do_wr) begin
			mem_ff[wp_ff] <= in_data;
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (do_wr) wp_ff <= inc(wp_ff);
			if (do_rd) rp_ff <= inc(rp_ff);
			cnt_ff <= cnt_ff + (do_wr ? 1'b1 : 1'b0) - (do_rd ? 1'b1 : 1'b0);
		end
	end
endmodule

// file: verif/pxb_bridge_checker.sv
`timescale 1ns/100ps
// ========
// Bridge checker
module pxb_bridge_checker (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic pcix_mode,
	input wire logic req_valid,
	input wire pxb_pkg::pxb_req_t req,
	input wire pxb_pkg::pxb_ans_t ans,
	input wire logic [7:0] ans_tag,
	input wire logic lnk_valid,
	input wire logic lnk_ready,
	input wire pxb_pkg::pxb_lnk_t lnk,
	input wire logic lnk_mst_req,
	input wire logic mst_req,
	input wire logic [12:0] mst_rd_limit
);
	import pxb_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire rd = req_valid && req.cmd == PXB_MEM_RD;
	wire wr = req_valid && req.cmd == PXB_MEM_WR;
	wire io = req_valid && req.cmd inside {PXB_IO, PXB_CFG};
	property p_io; io |=> ans == PXB_ANS_NONE; endproperty
	a_io: assert property (p_io) else $error("io answered");
	property p_tag; req_valid |=> ans_tag == $past(req.tag); endproperty
	a_tag: assert property (p_tag) else $error("tag lost");
	property p_crd;
		rd && !pcix_mode |=> ans inside {PXB_ANS_RETRY, PXB_ANS_ACK};
	endproperty
	a_crd: assert property (p_crd) else $error("bad read answer");
	property p_xrd;
		rd && pcix_mode |=> ans inside {PXB_ANS_SPLIT, PXB_ANS_RETRY};
	endproperty
	a_xrd: assert property (p_xrd) else $error("no split");
	property p_wr; wr |=> ans inside {PXB_ANS_ACK, PXB_ANS_RETRY}; endproperty
	a_wr: assert property (p_wr) else $error("bad write answer");
	property p_hold; lnk_valid && !lnk_ready |=> lnk_valid && $stable(lnk);
	endproperty
	a_hold: assert property (p_hold) else $error("link dropped");
	property p_mst; mst_req |-> lnk_mst_req; endproperty
	a_mst: assert property (p_mst) else $error("unasked request");
	property p_lim; mst_rd_limit == (pcix_mode ? 13'h1000 : 13'h0200);
	endproperty
	a_lim: assert property (p_lim) else $error("bad read limit");
	c_split: cover property (ans == PXB_ANS_SPLIT);
	c_ack: cover property (rd && !pcix_mode ##1 ans == PXB_ANS_ACK);
	c_full: cover property (wr ##1 ans == PXB_ANS_RETRY);
endmodule
bind pxb_bridge pxb_bridge_checker i_pxb_bridge_checker (.*);

// file: verif/pxb_link_model.sv
`timescale 1ns/100ps
// ========
// Linkage partner
module pxb_link_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic hold,
	input wire logic stall,
	input wire logic lnk_valid,
	output logic lnk_ready,
	input wire pxb_pkg::pxb_lnk_t lnk,
	output logic lnk_wdata_ready,
	output logic lnk_rdata_valid,
	input wire logic lnk_rdata_ready,
	output pxb_pkg::pxb_beat_t lnk_rdata,
	output logic [2:0] lnk_rdata_slot
);
	import pxb_pkg::*;
	pxb_lnk_t q[$];
	int k;
	wire busy = lnk_rdata_valid && !lnk_rdata_ready;
	// Hold starves the bridge so its queues fill; stall adds jitter
	assign lnk_ready = !hold && !stall;
	assign lnk_wdata_ready = !hold && !stall;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q.delete();
			k = 0;
			{lnk_rdata_valid, lnk_rdata, lnk_rdata_slot} <= '0;
		end else begin
			if (lnk_valid && lnk_ready && !lnk.wr)
				q.push_back(lnk);
			if (lnk_rdata_valid && lnk_rdata_ready) begin
				k = lnk_rdata.last ? 0 : k + 1;
				if (lnk_rdata.last)
					void'(q.pop_front());
			end
			if (!busy && q.size() > 0 && !hold && !stall) begin
				lnk_rdata_valid <= 1'b1;
				lnk_rdata <= '{q[0].addr + 64'(8 * k), 8'hff,
					8 * (k + 1) >= q[0].bcount};
				lnk_rdata_slot <= q[0].slot;
			end else if (!busy) begin
				lnk_rdata_valid <= 1'b0;
				// No stale data on a released bus
				lnk_rdata.data <= ~lnk_rdata.data;
			end
		end
	end
endmodule

// file: verif/testbench.sv
`timescale 1ns/100ps
// ========
// Testbench
module testbench;
	import pxb_pkg::*;
	logic mclk = 0, rst_n = 0, pcix_mode = 0, req_valid = 0, req_reg = 0;
	logic wbeat_valid = 0, rbeat_ready = 0, lnk_mst_req = 0, mst_gnt = 0;
	logic hold = 1, stall = 0, took = 0, wbeat_ready, rbeat_valid;
	logic rbeat_split, lnk_valid, lnk_ready, lnk_reg, lnk_wdata_ready;
	logic lnk_wdata_valid, lnk_rdata_valid, lnk_rdata_ready, mst_req;
	logic [7:0] ans_tag, rbeat_tag;
	logic [2:0] lnk_rdata_slot;
	logic [12:0] mst_rd_limit;
	logic [63:0] a;
	logic [73:0] qa[$], qb[$], qw[$], qr[$];
	pxb_req_t req = '0;
	pxb_beat_t wbeat = '0, rbeat, lnk_wdata, lnk_rdata;
	pxb_ans_t ans;
	pxb_lnk_t lnk;
	int bad_count = 0, tests_run = 0, seed = 14, i, j;
	pxb_bridge i_pxb_bridge (.*);
	pxb_link_model i_pxb_link_model (.*);
	always #10 mclk = ~mclk;
	always @(posedge mclk)
		{lnk_mst_req, mst_gnt, rbeat_ready, stall} <= 4'($random(seed));
	task automatic chk(input logic [73:0] seen, input logic [73:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		if (bad_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic issue(input pxb_cmd_t c, input logic [12:0] n,
		input logic [7:0] t, input pxb_ans_t e);
		req <= '{c, a, |a[63:32], n, t, 1'b1};
		req_valid <= 1;
		qa.push_back({e, t});
		if (c == PXB_MEM_WR && e == PXB_ANS_ACK)
			qr.push_back({req_reg, a});
		@(posedge mclk);
	endtask
	task automatic idle;
		req_valid <= 0;
		for (j = 0; j < 5000 && qb.size() + qw.size() > 0; j++)
			@(posedge mclk);
		if (j == 5000)
			bad_count++;
		@(posedge mclk);
	endtask
	task automatic put(input logic [63:0] d);
		wbeat <= '{d, 8'hff, 1'b1};
		wbeat_valid <= 1;
		qw.push_back(d);
		for (j = 0; j < 200; j++) begin
			@(posedge mclk);
			if (j == 20)
				hold <= 0;
			if (wbeat_ready)
				break;
		end
		if (j == 200)
			bad_count++;
	endtask
	always @(posedge mclk) begin
		if (took)
			chk({ans, ans_tag}, qa.pop_front());
		took = req_valid;
		if (rbeat_valid && rbeat_ready)
			chk({rbeat_split, rbeat.last, rbeat_split ? rbeat_tag : 8'h00,
				rbeat.data}, qb.pop_front());
		if (lnk_wdata_valid && lnk_wdata_ready)
			chk(lnk_wdata.data, qw.pop_front());
		if (lnk_valid && lnk_ready && lnk.wr)
			chk({lnk_reg, lnk.addr}, qr.pop_front());
	end
	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1;
		@(posedge mclk);
		a = 64'h40;
		for (i = 0; i < 4; i++) begin
			pcix_mode <= i[1];
			issue(i[0] ? PXB_CFG : PXB_IO, 13'h8, 8'(i), PXB_ANS_NONE);
		end
		pcix_mode <= 1;
		for (i = 0; i < 7; i++) begin
			a = {i[0] ? 32'h9 : 32'h0, 32'h1000 * i};
			issue(PXB_MEM_RD, 13'(8 * i + 8), 8'(i + 16),
				i < 6 ? PXB_ANS_SPLIT : PXB_ANS_RETRY);
			for (j = 0; j <= i && i < 6; j++)
				qb.push_back({1'b1, j == i, 8'(i + 16), a + 64'(8 * j)});
		end
		hold <= 0;
		idle;
		pcix_mode <= 0;
		a = 64'h2000;
		issue(PXB_MEM_RD, 13'h8, 8'h1, PXB_ANS_RETRY);
		// Prefetched beats reach the read stage before the reissue
		for (j = 0; j < 64; j++)
			qb.push_back({1'b0, j == 63, 8'h00, a + 64'(8 * j)});
		a = 64'h3000;
		issue(PXB_MEM_RD, 13'h8, 8'h2, PXB_ANS_RETRY);
		idle;
		a = 64'h2000;
		issue(PXB_MEM_RD, 13'h8, 8'h3, PXB_ANS_ACK);
		idle;
		pcix_mode <= 1;
		hold <= 1;
		for (i = 0; i < 41; i++) begin
			a = 64'h8000 + 64'(8 * i);
			issue(PXB_MEM_WR, 13'h8, 8'(i),
				i < 40 ? PXB_ANS_ACK : PXB_ANS_RETRY);
		end
		idle;
		for (i = 0; i < 40; i++)
			put(64'(i) ^ 64'h5a5a_0000);
		wbeat_valid <= 0;
		req_reg <= 1;
		idle;
		pcix_mode <= 0;
		a = 64'h9000;
		issue(PXB_MEM_WR, 13'h8, 8'h7, PXB_ANS_ACK);
		idle;
		put(64'h77);
		wbeat_valid <= 0;
		idle;
		repeat (20) @(posedge mclk);
		chk(qa.size() + qb.size() + qw.size() + qr.size(), 0);
		close_out;
	end
	initial begin
		#400000;
		bad_count++;
		close_out;
	end
endmodule
